// *** dv/bmfr_host_model.sv ***
// Host read requester standing in for the management bus master.
// Assumes the readout answers one cycle after the strobe it takes.
`timescale 1ns/100ps
module bmfr_host_model (
  input  wire logic       clk_sys,
  input  wire logic       go,
  input  wire logic [4:0] sel,
  input  wire logic       hi,
  input  wire logic       rd_valid,
  input  wire logic [7:0] rd_data,
  output logic            rd_stb,
  output logic [4:0]      rd_sel,
  output logic            rd_hi_byte,
  output logic            done,
  output logic [7:0]      got
);
  // Idle select toggles so a stale address cannot pass for a held one
  always_ff @(posedge clk_sys) begin
    rd_stb     <= go;
    rd_sel     <= go ? sel : ~rd_sel;
    rd_hi_byte <= go ? hi : ~rd_hi_byte;
    done       <= rd_valid;
    if (rd_valid) got <= rd_data;
  end
endmodule : bmfr_host_model

// *** dv/bmfr_readout_assertions.sv ***
// Port checker for the board monitor readout block.
// Bound into every bmfr_readout instance.
`timescale 1ns/100ps
module bmfr_readout_assertions #(
  parameter int unsigned SAMPLE_CYCLES = 16,
  parameter int unsigned LAMP_UNIT     = 4
) (
  input wire logic       clk_sys,
  input wire logic       rst,
  input wire logic       rd_stb,
  input wire logic [4:0] rd_sel,
  input wire logic       rd_valid,
  input wire logic [7:0] rd_data,
  input wire logic       fault_valid,
  input wire logic [4:0] fault_code,
  input wire logic       atx_mode,
  input wire logic       failsafe_image,
  input wire logic       blue_status_lamp
);
  logic [4:0]  exp_q;
  logic        seen_q;
  logic [31:0] on_q;
  wire         legal = fault_valid && fault_code != 5'h01 && fault_code != 5'h0D && fault_code <= 5'h16;
  always_ff @(posedge clk_sys) begin
    exp_q  <= rst ? 5'h00 : (legal ? fault_code : exp_q);
    seen_q <= !rst && (seen_q || (legal && fault_code != 5'h00));
    on_q   <= (rst || !blue_status_lamp) ? 32'h0 : on_q + 32'h1;
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  read_gets_answer_a: assert property (rd_stb |=> rd_valid) else $error("read unanswered");
  no_stray_answer_a: assert property (!rd_stb |=> !rd_valid) else $error("stray answer");
  data_holds_a: assert property (!rd_valid |-> $stable(rd_data)) else $error("data moved");
  ch15_no_volt_a: assert property (rd_stb && rd_sel == 5'h0F |=> rd_data == 8'h00) else $error("ch15 data");
  unmapped_zero_a: assert property (rd_stb && rd_sel > 5'h15 |=> rd_data == 8'h00) else $error("unmapped");
  fault_field_a: assert property (rd_stb && rd_sel == 5'h15 |=> rd_data[4:0] == $past(exp_q))
    else $error("fault field");
  mode_bits_a: assert property ($stable({atx_mode, failsafe_image})[*3] ##0 (rd_stb && rd_sel == 5'h15)
    |=> rd_data[7:5] == {$past(failsafe_image), $past(atx_mode), 1'b0}) else $error("mode bits");
  lamp_unit_a: assert property ($fell(blue_status_lamp) |-> on_q == LAMP_UNIT) else $error("lamp width");
  lamp_dark_a: assert property (!seen_q |-> !blue_status_lamp) else $error("lamp without fault");
endmodule : bmfr_readout_assertions

bind bmfr_readout bmfr_readout_assertions #(.SAMPLE_CYCLES(SAMPLE_CYCLES), .LAMP_UNIT(LAMP_UNIT))
  i_bmfr_readout_assertions (.clk_sys, .rst, .rd_stb, .rd_sel, .rd_valid, .rd_data, .fault_valid, .fault_code,
  .atx_mode, .failsafe_image, .blue_status_lamp);

// *** dv/testbench.sv ***
// Self-checking bench for bmfr_readout driven through a host read model.
// Assumes short counts: 16-cycle sampling tick and 4-cycle lamp unit.
`timescale 1ns/100ps
module testbench;
  logic clk_sys = 0, rst = 1, go = 0, hi = 0, volt_valid = 0, fault_valid = 0, atx_mode = 0, failsafe_image = 0;
  logic [4:0]  sel = 0, fault_code = 0, e = 5'h07;
  logic [3:0]  volt_chan = 0;
  logic [15:0] volt_value = 0, current_value = 0;
  logic [7:0]  pins = 0, rd_data, got;
  logic [4:0]  rd_sel;
  logic        rd_stb, rd_hi_byte, rd_valid, done, blue_status_lamp, l;
  int          n_errors = 0, checks = 0, cyc = 0, k, r;
  bmfr_host_model i_bmfr_host_model (.clk_sys, .go, .sel, .hi, .rd_valid, .rd_data, .rd_stb, .rd_sel, .rd_hi_byte,
    .done, .got);
  bmfr_readout #(.SAMPLE_CYCLES(16), .LAMP_UNIT(4)) i_bmfr_readout (.clk_sys, .rst, .rd_stb, .rd_sel, .rd_hi_byte,
    .rd_valid, .rd_data, .volt_valid, .volt_chan, .volt_value, .current_value, .fault_valid, .fault_code,
    .watchdog_output(pins[0]), .panel_power_enable(pins[1]), .backlight_enable(pins[2]),
    .firmware_operating_mode(pins[3]), .boot_watchdog_disable_n(pins[4]), .firmware_image_select(pins[5]),
    .firmware_chip0_disable_n(pins[6]), .firmware_chip1_disable_n(pins[7]), .atx_mode, .failsafe_image,
    .blue_status_lamp);
  always #2.5 clk_sys = ~clk_sys;
  task automatic stop_test();
    if (n_errors == 0 && checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : stop_test
  // Whole run needs well under a thousand cycles
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_errors++;
      stop_test();
    end
  end
  task automatic cmp(string nm, logic [7:0] exp, logic [7:0] act);
    checks++;
    if (act !== exp) begin
      n_errors++;
      $display("FAIL %s exp %h got %h", nm, exp, act);
    end
  endtask : cmp
  task automatic rd(logic [4:0] s, logic h, logic [7:0] exp);
    go = 1; sel = s; hi = h;
    @(posedge clk_sys) #1 go = 0;
    for (int w = 0; w < 8 && done !== 1'b1; w++) @(posedge clk_sys) #1;
    cmp($sformatf("sel %h hi %b", s, h), exp, got);
  endtask : rd
  task automatic set_fault(logic [4:0] c);
    fault_code = c; fault_valid = 1;
    @(posedge clk_sys) #1 fault_valid = 0;
    @(posedge clk_sys) #1;
  endtask : set_fault
  initial begin
    repeat (16) @(posedge clk_sys);
    #1 rst = 0;
    rd(5'h15, 0, 8'h00);
    volt_chan = 4'hE; volt_value = 16'hA5C3; volt_valid = 1;
    @(posedge clk_sys) #1 volt_chan = 4'hF; volt_value = 16'h1234;
    @(posedge clk_sys) #1 volt_valid = 0;
    rd(5'h0E, 1, 8'hA5);
    rd(5'h0E, 0, 8'hC3);
    rd(5'h0F, 1, 8'h00);
    rd(5'h1F, 0, 8'h00);
    pins = 8'hA5; atx_mode = 1;
    set_fault(5'h16);
    rd(5'h14, 0, 8'hA5);
    rd(5'h15, 0, 8'h56);
    pins = 8'h5A; failsafe_image = 1;
    set_fault(5'h07);
    rd(5'h14, 0, 8'h5A);
    rd(5'h15, 0, 8'hC7);
    // An inter-train gap is longer than any off pulse, so 8 dark cycles frame a train
    k = 0; r = 0; l = 0;
    while (k < 8) @(posedge clk_sys) #1 k = blue_status_lamp ? 0 : k + 1;
    k = 0;
    while (k < 8 || r == 0) begin
      @(posedge clk_sys) #1 r += (blue_status_lamp && !l);
      l = blue_status_lamp;
      k = l ? 0 : k + 1;
    end
    cmp("lamp pulses", 8'h07, r[7:0]);
    for (int c = 0; c < 32; c++) begin
      set_fault(c[4:0]);
      if (c != 1 && c != 13 && c <= 22) e = c[4:0];
      rd(5'h15, 0, {3'b110, e});
    end
    // Slots hold equal values, so no time order is assumed
    for (int v = 0; v < 2; v++) begin
      current_value = v ? 16'hCAFE : 16'hBEEF;
      repeat (68) @(posedge clk_sys);
      #1;
      for (int s = 0; s < 8; s++) rd(5'h10 + 5'(s / 2), s[0], s[0] ? current_value[15:8] : current_value[7:0]);
    end
    stop_test();
  end
endmodule : testbench

// *** verilog/bmfr_cfg.svh ***
// Constants for the board monitor and fault reporting readout block.
// Assumes inclusion by the package and the block; definitions only.
`ifndef BMFR_CFG_SVH
`define BMFR_CFG_SVH

`define BMFR_CLK_MHZ          200
`define BMFR_SAMPLE_MS        250
`define BMFR_SAMPLE_CYCLES    (`BMFR_SAMPLE_MS * 1000 * `BMFR_CLK_MHZ)
`define BMFR_SEL_VOLT_BASE    5'h00
`define BMFR_SEL_CURRENT_CH   5'h0F
`define BMFR_SEL_CURRENT0     5'h10
`define BMFR_SEL_STATUS       5'h14
`define BMFR_SEL_FLAGS        5'h15
`define BMFR_FLAG_CODE_LSB    0
`define BMFR_FLAG_CODE_MSB    4
`define BMFR_FLAG_RSVD_BIT    5
`define BMFR_FLAG_ATX_BIT     6
`define BMFR_FLAG_FAILSAFE_BIT 7
`define BMFR_FAULT_NONE       5'h00
`define BMFR_FAULT_RSVD_LO    5'h01
`define BMFR_FAULT_RSVD_HI    5'h0D
`define BMFR_LAMP_UNIT_CYCLES 32'h02FA_F080
`define BMFR_LAMP_GAP_PULSES  5'h03

`endif

// *** verilog/bmfr_pkg.sv ***
// Types shared by the board monitor readout block.
// Assumes bmfr_cfg.svh on the include path.
`include "bmfr_cfg.svh"
package bmfr_pkg;
  typedef enum logic [4:0] {
    BMFR_FAULT_NONE_E          = 5'h00,
    BMFR_FAULT_SUSPEND_CLOCK   = 5'h02,
    BMFR_FAULT_SLEEP_S5        = 5'h03,
    BMFR_FAULT_SLEEP_S4        = 5'h04,
    BMFR_FAULT_SLEEP_S3        = 5'h05,
    BMFR_FAULT_CARRIER_GOOD    = 5'h06,
    BMFR_FAULT_FIRMWARE        = 5'h07,
    BMFR_FAULT_RESET           = 5'h08,
    BMFR_FAULT_RESET_IN        = 5'h09,
    BMFR_FAULT_CRIT_TEMP       = 5'h0A,
    BMFR_FAULT_POWER           = 5'h0B,
    BMFR_FAULT_VOLTAGE         = 5'h0C,
    BMFR_FAULT_RAIL_FIRST      = 5'h0E,
    BMFR_FAULT_RAIL_LAST       = 5'h16
  } bmfr_fault_e;
  typedef enum logic [1:0] {BMFR_LAMP_IDLE, BMFR_LAMP_ON, BMFR_LAMP_OFF, BMFR_LAMP_GAP} bmfr_lamp_e;
endpackage : bmfr_pkg

// *** verilog/bmfr_readout.sv ***
// Readout block of the board management controller: voltage monitor, main
// current ring, status byte, flags byte and fault lamp blinker.
// Assumes the host bus target logic presents a 5-bit item select and a read
// strobe, and that converter samples arrive as same-clock valid pulses.
`timescale 1ns/100ps
`include "bmfr_cfg.svh"
module bmfr_readout
  import bmfr_pkg::*;
#(
  parameter int unsigned SAMPLE_CYCLES = `BMFR_SAMPLE_CYCLES,
  parameter int unsigned LAMP_UNIT     = `BMFR_LAMP_UNIT_CYCLES
) (
  input  wire logic        clk_sys,
  input  wire logic        rst,
  input  wire logic        rd_stb,
  input  wire logic [4:0]  rd_sel,
  input  wire logic        rd_hi_byte,
  output logic             rd_valid,
  output logic [7:0]       rd_data,
  input  wire logic        volt_valid,
  input  wire logic [3:0]  volt_chan,
  input  wire logic [15:0] volt_value,
  input  wire logic [15:0] current_value,
  input  wire logic        fault_valid,
  input  wire logic [4:0]  fault_code,
  input  wire logic        watchdog_output,
  input  wire logic        panel_power_enable,
  input  wire logic        backlight_enable,
  input  wire logic        firmware_operating_mode,
  input  wire logic        boot_watchdog_disable_n,
  input  wire logic        firmware_image_select,
  input  wire logic        firmware_chip0_disable_n,
  input  wire logic        firmware_chip1_disable_n,
  input  wire logic        atx_mode,
  input  wire logic        failsafe_image,
  output logic             blue_status_lamp
);

  // Board signals arrive from pins, so two flops before use
  logic [9:0] pins_raw;
  logic [9:0] pins_meta_q;
  logic [9:0] pins_sync_q;
  assign pins_raw = {failsafe_image, atx_mode, firmware_chip1_disable_n, firmware_chip0_disable_n,
                     firmware_image_select, boot_watchdog_disable_n, firmware_operating_mode,
                     backlight_enable, panel_power_enable, watchdog_output};
  always_ff @(posedge clk_sys) begin
    pins_meta_q <= pins_raw;
    pins_sync_q <= pins_meta_q;
  end

  // Voltage channel store; channel 15 is never written
  logic [15:0] volt_mem_q [0:14];
  logic        volt_wr;
  assign volt_wr = volt_valid && (volt_chan != `BMFR_SEL_CURRENT_CH);
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      for (int i = 0; i < 15; i++) volt_mem_q[i] <= 16'h0000;
    end else if (volt_wr) begin
      volt_mem_q[volt_chan] <= volt_value;
    end
  end

  // Current ring: slot order follows the write pointer, not age
  logic [31:0] tick_cnt_q;
  logic        tick;
  logic [1:0]  cur_ptr_q;
  logic [15:0] cur_mem_q [0:3];
  assign tick = (tick_cnt_q == SAMPLE_CYCLES - 1);
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      tick_cnt_q <= 32'h0000_0000;
      cur_ptr_q  <= 2'h0;
      for (int i = 0; i < 4; i++) cur_mem_q[i] <= 16'h0000;
    end else begin
      tick_cnt_q <= tick ? 32'h0000_0000 : tick_cnt_q + 32'h0000_0001;
      if (tick) begin
        cur_mem_q[cur_ptr_q] <= current_value;
        cur_ptr_q            <= cur_ptr_q + 2'h1;
      end
    end
  end

  // Fault code latch; reset or code 00 clears it, reserved codes are ignored
  logic [4:0] fault_q;
  logic       fault_ok;
  assign fault_ok = fault_valid && (fault_code != `BMFR_FAULT_RSVD_LO) && (fault_code != `BMFR_FAULT_RSVD_HI)
                    && (fault_code <= BMFR_FAULT_RAIL_LAST);
  always_ff @(posedge clk_sys) begin
    if (rst) fault_q <= `BMFR_FAULT_NONE;
    else if (fault_ok) fault_q <= fault_code;
  end

  logic [7:0] status_byte;
  logic [7:0] flags_byte;
  assign status_byte = pins_sync_q[7:0];
  assign flags_byte  = {pins_sync_q[9], pins_sync_q[8], 1'b0, fault_q};

  // Read mux: item select and byte half
  logic [15:0] word_sel;
  logic [7:0]  rd_byte;
  logic [1:0]  cur_idx;
  // Current slots start on a four-aligned select, so the low bits are the slot
  assign cur_idx  = rd_sel[1:0];
  assign word_sel = (rd_sel < `BMFR_SEL_CURRENT_CH) ? volt_mem_q[rd_sel[3:0]] :
                    (rd_sel >= `BMFR_SEL_CURRENT0 && rd_sel < `BMFR_SEL_STATUS) ? cur_mem_q[cur_idx] :
                    16'h0000;
  assign rd_byte  = (rd_sel == `BMFR_SEL_STATUS) ? status_byte :
                    (rd_sel == `BMFR_SEL_FLAGS)  ? flags_byte  :
                    (rd_hi_byte ? word_sel[15:8] : word_sel[7:0]);
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      rd_valid <= 1'b0;
      rd_data  <= 8'h00;
    end else begin
      rd_valid <= rd_stb;
      rd_data  <= rd_stb ? rd_byte : rd_data;
    end
  end

  // Lamp blinker: code pulses then a gap; code is re-read each round so a newer fault shows next
  bmfr_lamp_e  lamp_st_q;
  logic [31:0] lamp_cnt_q;
  logic [4:0]  lamp_left_q;
  logic        unit_done;
  assign unit_done = (lamp_cnt_q == LAMP_UNIT - 1);
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      lamp_st_q        <= BMFR_LAMP_IDLE;
      lamp_cnt_q       <= 32'h0000_0000;
      lamp_left_q      <= 5'h00;
      blue_status_lamp <= 1'b0;
    end else begin
      lamp_cnt_q <= unit_done ? 32'h0000_0000 : lamp_cnt_q + 32'h0000_0001;
      case (lamp_st_q)
        BMFR_LAMP_IDLE: begin
          blue_status_lamp <= 1'b0;
          lamp_cnt_q       <= 32'h0000_0000;
          if (fault_q != `BMFR_FAULT_NONE) begin
            lamp_st_q        <= BMFR_LAMP_ON;
            lamp_left_q      <= fault_q;
            blue_status_lamp <= 1'b1;
          end
        end
        BMFR_LAMP_ON: if (unit_done) begin
          blue_status_lamp <= 1'b0;
          lamp_left_q      <= lamp_left_q - 5'h01;
          lamp_st_q        <= BMFR_LAMP_OFF;
        end
        BMFR_LAMP_OFF: if (unit_done) begin
          if (lamp_left_q != 5'h00) begin
            blue_status_lamp <= 1'b1;
            lamp_st_q        <= BMFR_LAMP_ON;
          end else begin
            lamp_left_q <= `BMFR_LAMP_GAP_PULSES;
            lamp_st_q   <= BMFR_LAMP_GAP;
          end
        end
        BMFR_LAMP_GAP: if (unit_done) begin
          lamp_left_q <= lamp_left_q - 5'h01;
          if (lamp_left_q == 5'h01) lamp_st_q <= BMFR_LAMP_IDLE;
        end
        default: lamp_st_q <= BMFR_LAMP_IDLE;
      endcase
    end
  end

endmodule : bmfr_readout
